// ---- pkg/lfosc_pkg.sv ----
package lfosc_pkg;

	// serial opcodes
	localparam logic [7:0] OP_WR_OSC = 8'h43;
	localparam logic [7:0] OP_RD_OSC = 8'hC3;
	localparam logic [7:0] OP_RD_FLAGS = 8'hFE;

	// serial frame: opcode then one 16-bit word
	localparam logic [4:0] OPCODE_BITS = 5'h08;
	localparam logic [4:0] FRAME_BITS = 5'h18;

	// low-frequency oscillator control register
	localparam int OSC_BYPASS_BIT = 6;
	localparam int OSC_OUTEN_BIT = 5;
	localparam int OSC_STOP_BIT = 4;
	localparam logic [15:0] OSC_WR_MASK = 16'h0070;
	localparam logic [15:0] OSC_RESET = 16'h0000;

	// event flag register
	localparam int FLAG_TIMEOUT_BIT = 15;
	localparam int FLAG_FLIGHT_BIT = 12;
	localparam int FLAG_TEMP_BIT = 11;
	localparam int FLAG_CAL_BIT = 6;
	localparam int FLAG_INIT_BIT = 3;
	localparam int FLAG_POR_BIT = 2;
	localparam logic [15:0] FLAGS_RESET = 16'h0000;

	// timing
	localparam int SYS_CLK_HZ = 20_000_000;
	localparam int LF_CLK_HZ = 32768;
	localparam int POR_WAIT_US = 10;
	localparam int POR_W = 8;
	localparam logic [POR_W-1:0] POR_WAIT_LAST =
		POR_W'((POR_WAIT_US * (SYS_CLK_HZ / 1_000_000) + 0) - 1);
	localparam int DIV_W = 9;
	localparam logic [DIV_W-1:0] LF_HALF_LAST =
		DIV_W'(SYS_CLK_HZ / (2 * LF_CLK_HZ) - 1);

	// serial frame state, gray along idle -> opcode -> data
	typedef enum logic [1:0] {
		LFOSC_IDLE = 2'h0,
		LFOSC_OPC = 2'h1,
		LFOSC_DATA = 2'h3
	} lfosc_frame_t;

endpackage

// ---- pkg/lfosc_spi_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface lfosc_spi_if;
	logic enable;
	logic opStrobe;
	logic wrStrobe;
	logic frameActive;
	logic misoBit;
	logic [7:0] opcode;
	logic [15:0] wrData;
	logic [15:0] rdData;

	modport shifter (
		input enable, rdData,
		output opStrobe, wrStrobe, frameActive, misoBit, opcode, wrData
	);
	modport regs (
		output enable, rdData,
		input opStrobe, wrStrobe, frameActive, misoBit, opcode, wrData
	);
endinterface
`default_nettype wire

// ---- design/lfosc_spi_shift.sv ----
`timescale 1ns/1ps
`default_nettype none
module lfosc_spi_shift
	import lfosc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// serial pins
	input wire logic sclkPin,
	input wire logic csPinN,
	input wire logic mosiPin,
	// register side
	lfosc_spi_if.shifter bus
);

	// pin order: sclk, chip select, data in
	logic [2:0] pinS1_r, pinS2_r, pinS3_r;
	logic [2:0] pinS1_nxt, pinS2_nxt, pinS3_nxt;

	always_comb begin
		pinS1_nxt = {sclkPin, csPinN, mosiPin};
		pinS2_nxt = pinS1_r;
		pinS3_nxt = pinS2_r;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pinS1_r <= 3'h2;
			pinS2_r <= 3'h2;
			pinS3_r <= 3'h2;
		end else begin
			pinS1_r <= pinS1_nxt;
			pinS2_r <= pinS2_nxt;
			pinS3_r <= pinS3_nxt;
		end
	end

	lfosc_frame_t state_r, state_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [15:0] rx_r, rx_nxt, tx_r, tx_nxt, wd_r, wd_nxt;
	logic [7:0] op_r, op_nxt;
	logic opS_r, opS_nxt, wrS_r, wrS_nxt, load_r, load_nxt;
	logic rise, fall, csActive;

	always_comb begin
		rise = pinS2_r[2] & ~pinS3_r[2];
		fall = ~pinS2_r[2] & pinS3_r[2];
		csActive = ~pinS2_r[1] & bus.enable;
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		rx_nxt = rx_r;
		tx_nxt = tx_r;
		wd_nxt = wd_r;
		op_nxt = op_r;
		opS_nxt = 1'b0;
		wrS_nxt = 1'b0;
		load_nxt = opS_r;
		case (state_r)
			LFOSC_IDLE: begin
				cnt_nxt = 5'h00;
				if (csActive) begin
					state_nxt = LFOSC_OPC;
				end
			end
			LFOSC_OPC: begin
				if (rise) begin
					rx_nxt = {rx_r[14:0], pinS2_r[0]};
					cnt_nxt = cnt_r + 5'h01;
					if (cnt_r == OPCODE_BITS - 5'h01) begin
						op_nxt = {rx_r[6:0], pinS2_r[0]};
						opS_nxt = 1'b1;
						state_nxt = LFOSC_DATA;
					end
				end
			end
			LFOSC_DATA: begin
				if (rise && cnt_r != FRAME_BITS) begin
					rx_nxt = {rx_r[14:0], pinS2_r[0]};
					cnt_nxt = cnt_r + 5'h01;
					if (cnt_r == FRAME_BITS - 5'h01) begin
						wd_nxt = {rx_r[14:0], pinS2_r[0]};
						wrS_nxt = 1'b1;
					end
				end
				// first data bit stays until after the ninth rising edge
				if (fall && cnt_r > OPCODE_BITS) begin
					tx_nxt = {tx_r[14:0], 1'b0};
				end
			end
			default: begin
				state_nxt = LFOSC_IDLE;
			end
		endcase
		if (load_r) begin
			tx_nxt = bus.rdData;
		end
		if (!csActive) begin
			state_nxt = LFOSC_IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state_r <= LFOSC_IDLE;
			cnt_r <= 5'h00;
			rx_r <= 16'h0000;
			tx_r <= 16'h0000;
			wd_r <= 16'h0000;
			op_r <= 8'h00;
			opS_r <= 1'b0;
			wrS_r <= 1'b0;
			load_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			rx_r <= rx_nxt;
			tx_r <= tx_nxt;
			wd_r <= wd_nxt;
			op_r <= op_nxt;
			opS_r <= opS_nxt;
			wrS_r <= wrS_nxt;
			load_r <= load_nxt;
		end
	end

	assign bus.opStrobe = opS_r;
	assign bus.wrStrobe = wrS_r;
	assign bus.opcode = op_r;
	assign bus.wrData = wd_r;
	assign bus.misoBit = tx_r[15];
	assign bus.frameActive = (state_r == LFOSC_DATA);

endmodule
`default_nettype wire

// ---- design/lfosc_ctrl_flags.sv ----
`timescale 1ns/1ps
`default_nettype none
module lfosc_ctrl_flags
	import lfosc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// serial register port
	input wire logic sclkPin,
	input wire logic csPinN,
	input wire logic mosiPin,
	output logic misoPin,
	output logic misoOen,
	// low-frequency clock
	input wire logic crystalInPin,
	output logic lowFreqClockOutPin,
	output logic lowFreqTick,
	output logic lowFreqBypass,
	output logic lowFreqOutEnable,
	output logic oscStop,
	// events from measurement logic, one-cycle pulses
	input wire logic [5:0] measTimeout,
	input wire logic upstreamFlightCmdDone,
	input wire logic downstreamFlightCmdDone,
	input wire logic differentialFlightCmdDone,
	input wire logic tempCmdDone,
	input wire logic calCmdDone,
	input wire logic initCmdDone,
	// status
	output logic portReady
);

	lfosc_spi_if bus ();

	lfosc_spi_shift u_shift (
		.sys_clk(sys_clk),
		.resetn(resetn),
		.sclkPin(sclkPin),
		.csPinN(csPinN),
		.mosiPin(mosiPin),
		.bus(bus)
	);

	// power-up wait
	logic [POR_W-1:0] porCnt_r, porCnt_nxt;
	logic ready_r, ready_nxt, porSet;

	always_comb begin
		porCnt_nxt = porCnt_r;
		ready_nxt = ready_r;
		porSet = 1'b0;
		if (!ready_r) begin
			porCnt_nxt = porCnt_r + POR_W'(1);
			if (porCnt_r == POR_WAIT_LAST) begin
				ready_nxt = 1'b1;
				porSet = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			porCnt_r <= '0;
			ready_r <= 1'b0;
		end else begin
			porCnt_r <= porCnt_nxt;
			ready_r <= ready_nxt;
		end
	end

	// registers and read path
	logic [15:0] osc_r, osc_nxt, flags_r, flags_nxt;
	logic [15:0] rdHold_r, rdHold_nxt, events;

	always_comb begin
		events = 16'h0000;
		events[FLAG_TIMEOUT_BIT] = |measTimeout;
		events[FLAG_FLIGHT_BIT] = upstreamFlightCmdDone |
			downstreamFlightCmdDone | differentialFlightCmdDone;
		events[FLAG_TEMP_BIT] = tempCmdDone;
		events[FLAG_CAL_BIT] = calCmdDone;
		events[FLAG_INIT_BIT] = initCmdDone;
		events[FLAG_POR_BIT] = porSet;
		osc_nxt = osc_r;
		rdHold_nxt = rdHold_r;
		flags_nxt = flags_r | events;
		if (bus.wrStrobe && bus.opcode == OP_WR_OSC) begin
			osc_nxt = bus.wrData & OSC_WR_MASK;
		end
		if (bus.opStrobe) begin
			case (bus.opcode)
				OP_RD_OSC: begin
					rdHold_nxt = osc_r;
				end
				OP_RD_FLAGS: begin
					rdHold_nxt = flags_r;
					flags_nxt = events;
				end
				default: begin
					rdHold_nxt = 16'h0000;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			osc_r <= OSC_RESET;
			flags_r <= FLAGS_RESET;
			rdHold_r <= 16'h0000;
		end else begin
			osc_r <= osc_nxt;
			flags_r <= flags_nxt;
			rdHold_r <= rdHold_nxt;
		end
	end

	assign bus.enable = ready_r;
	assign bus.rdData = rdHold_r;

	// low-frequency clock source
	logic xS1_r, xS2_r, xS1_nxt, xS2_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic intLvl_r, intLvl_nxt, lfLvl_r, lfLvl_nxt;
	logic tick_r, tick_nxt, out_r, out_nxt, srcLvl;

	always_comb begin
		xS1_nxt = crystalInPin;
		xS2_nxt = xS1_r;
		div_nxt = div_r;
		intLvl_nxt = intLvl_r;
		// oscillator runs while stop bit low
		if (!osc_r[OSC_STOP_BIT]) begin
			div_nxt = div_r + DIV_W'(1);
			if (div_r == LF_HALF_LAST) begin
				div_nxt = '0;
				intLvl_nxt = ~intLvl_r;
			end
		end else begin
			div_nxt = '0;
		end
		srcLvl = osc_r[OSC_BYPASS_BIT] ? xS2_r : intLvl_r;
		lfLvl_nxt = srcLvl;
		tick_nxt = srcLvl & ~lfLvl_r;
		out_nxt = osc_r[OSC_OUTEN_BIT] & srcLvl;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			xS1_r <= 1'b0;
			xS2_r <= 1'b0;
			div_r <= '0;
			intLvl_r <= 1'b0;
			lfLvl_r <= 1'b0;
			tick_r <= 1'b0;
			out_r <= 1'b0;
		end else begin
			xS1_r <= xS1_nxt;
			xS2_r <= xS2_nxt;
			div_r <= div_nxt;
			intLvl_r <= intLvl_nxt;
			lfLvl_r <= lfLvl_nxt;
			tick_r <= tick_nxt;
			out_r <= out_nxt;
		end
	end

	// serial data out, released outside the data phase
	logic miso_r, miso_nxt, oen_r, oen_nxt;

	always_comb begin
		miso_nxt = bus.misoBit;
		oen_nxt = ~bus.frameActive;
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			miso_r <= 1'b0;
			oen_r <= 1'b1;
		end else begin
			miso_r <= miso_nxt;
			oen_r <= oen_nxt;
		end
	end

	assign misoPin = miso_r;
	assign misoOen = oen_r;
	assign lowFreqClockOutPin = out_r;
	assign lowFreqTick = tick_r;
	assign lowFreqBypass = osc_r[OSC_BYPASS_BIT];
	assign lowFreqOutEnable = osc_r[OSC_OUTEN_BIT];
	assign oscStop = osc_r[OSC_STOP_BIT];
	assign portReady = ready_r;

endmodule
`default_nettype wire

// ---- bench/lfosc_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module lfosc_host_model (
	// clock
	input wire logic sysClk,
	// serial pins
	input wire logic misoPin,
	output logic sclkPin,
	output logic csPinN,
	output logic mosiPin
);
	initial begin
		sclkPin = 1'b0;
		csPinN = 1'b1;
		mosiPin = 1'b0;
	end
	// mode 0: data set while sclk low, miso sampled on each rise of the 16 data bits
	// bits below 24 abort the frame by raising chip select early
	task automatic xfer(input logic [23:0] frm, input int bits,
		output logic [15:0] rd);
		rd = 16'h0000;
		@(negedge sysClk) csPinN = 1'b0;
		for (int i = 23; i >= 24 - bits; i--) begin
			mosiPin = frm[i];
			repeat (4) @(negedge sysClk);
			sclkPin = 1'b1;
			if (i < 16) begin
				rd = {rd[14:0], misoPin};
			end
			repeat (4) @(negedge sysClk);
			sclkPin = 1'b0;
		end
		repeat (4) @(negedge sysClk);
		csPinN = 1'b1;
		mosiPin = ~mosiPin;
		repeat (6) @(negedge sysClk);
	endtask
endmodule
`default_nettype wire

// ---- bench/lfosc_ctrl_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module lfosc_ctrl_properties (
	// clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	// observed outputs and clock pin
	input wire logic misoOen,
	input wire logic crystalInPin,
	input wire logic lowFreqClockOutPin,
	input wire logic lowFreqTick,
	input wire logic lowFreqBypass,
	input wire logic lowFreqOutEnable,
	input wire logic oscStop,
	input wire logic portReady
);
	logic [8:0] porCnt_r;
	always_ff @(posedge sys_clk) begin
		if (!resetn || portReady) porCnt_r <= 9'h000;
		else porCnt_r <= porCnt_r + 9'h001;
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// guards skip the switch-over between internal and external clock
	property p_bypass_tick;
		lowFreqBypass && $past(lowFreqBypass, 8) && $rose(crystalInPin)
			|-> ##[1:6] lowFreqTick;
	endproperty
	property p_out_follow;
		lowFreqOutEnable && $past(lowFreqOutEnable, 8) && lowFreqBypass &&
			$past(lowFreqBypass, 8) && $rose(crystalInPin)
			|-> ##[1:6] lowFreqClockOutPin;
	endproperty
	property p_out_off;
		!lowFreqOutEnable && !$past(lowFreqOutEnable) |-> !lowFreqClockOutPin;
	endproperty
	property p_run_tick;
		!oscStop && !lowFreqBypass
			|-> ##[0:700] (lowFreqTick || oscStop || lowFreqBypass);
	endproperty
	property p_stop_quiet;
		oscStop && $past(oscStop, 6) && !lowFreqBypass &&
			!$past(lowFreqBypass, 6) |-> !lowFreqTick;
	endproperty
	property p_por_wait;
		$rose(portReady) |-> porCnt_r inside {[9'h0C7:9'h0C9]};
	endproperty
	property p_ready_hold;
		portReady |=> portReady;
	endproperty
	property p_quiet_early;
		!portReady |-> misoOen;
	endproperty
	a_bypass_tick: assert property (p_bypass_tick)
		else $error("no tick from external clock");
	a_out_follow: assert property (p_out_follow)
		else $error("clock out does not follow");
	a_out_off: assert property (p_out_off)
		else $error("clock out high while disabled");
	a_run_tick: assert property (p_run_tick)
		else $error("running oscillator gives no tick");
	a_stop_quiet: assert property (p_stop_quiet)
		else $error("stopped oscillator ticks");
	a_por_wait: assert property (p_por_wait)
		else $error("power-up wait length wrong");
	a_ready_hold: assert property (p_ready_hold)
		else $error("port ready dropped");
	a_quiet_early: assert property (p_quiet_early)
		else $error("data driven before port ready");
	c_bypass: cover property (lowFreqBypass && lowFreqTick);
	c_read: cover property ($fell(misoOen));
	c_ready: cover property ($rose(portReady));
endmodule
bind lfosc_ctrl_flags lfosc_ctrl_properties lfosc_ctrl_properties_inst (
	.sys_clk, .resetn, .misoOen, .crystalInPin, .lowFreqClockOutPin,
	.lowFreqTick, .lowFreqBypass, .lowFreqOutEnable, .oscStop, .portReady
);
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import lfosc_pkg::*;
	logic sys_clk = 1'b0;
	logic resetn = 1'b0;
	logic crystalInPin = 1'b0;
	logic [11:0] ev = 12'h000;
	logic sclkPin, csPinN, mosiPin, misoPin, misoOen;
	logic lowFreqClockOutPin, lowFreqTick, lowFreqBypass;
	logic lowFreqOutEnable, oscStop, portReady;
	logic [15:0] rd;
	logic [15:0] rdFirst;
	logic misoLine;
	int failures = 0;
	int checks_done = 0;
	int n;
	// event vector beside the flag word it should leave
	logic [27:0] rows [12] = '{28'h8008000, 28'h4008000, 28'h2008000,
		28'h1008000, 28'h0808000, 28'h0408000, 28'h0201000, 28'h0101000,
		28'h0081000, 28'h0040800, 28'h0020040, 28'h0010008};
	always #25 sys_clk = ~sys_clk;
	// an external oscillator runs free, unlike the serial clock
	// this half period keeps every pin edge off the sampling edge
	always #15260 crystalInPin = ~crystalInPin;
	// a released line shows the inverse, so a late drive is caught
	assign misoLine = misoOen ? ~misoPin : misoPin;
	lfosc_host_model lfosc_host_model_inst (.sysClk(sys_clk),
		.misoPin(misoLine), .sclkPin, .csPinN, .mosiPin);
	lfosc_ctrl_flags lfosc_ctrl_flags_inst (.sys_clk, .resetn, .sclkPin,
		.csPinN, .mosiPin, .misoPin, .misoOen, .crystalInPin,
		.lowFreqClockOutPin, .lowFreqTick, .lowFreqBypass, .lowFreqOutEnable,
		.oscStop, .measTimeout(ev[11:6]), .upstreamFlightCmdDone(ev[5]),
		.downstreamFlightCmdDone(ev[4]), .differentialFlightCmdDone(ev[3]),
		.tempCmdDone(ev[2]), .calCmdDone(ev[1]), .initCmdDone(ev[0]),
		.portReady);
	task automatic finish_test;
		$display("failures %0d checks %0d", failures, checks_done);
		if (failures == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// write frames have no defined read-back, so only reads compare
	task automatic rw(input logic [7:0] op, input logic [15:0] wd,
		input logic [15:0] exp);
		lfosc_host_model_inst.xfer({op, wd}, 24, rd);
		if (op[7]) begin
			cmp(rd, exp);
		end
	endtask
	task automatic do_reset;
		@(negedge sys_clk) resetn = 1'b0;
		repeat (16) @(negedge sys_clk);
		cmp(16'({lowFreqBypass, lowFreqOutEnable, oscStop, portReady}),
			16'h0000);
		resetn = 1'b1;
		n = 0;
		while (portReady !== 1'b1 && n < 400) begin
			@(negedge sys_clk);
			n++;
		end
		if (n == 400) begin
			failures++;
			finish_test;
		end
	endtask
	task automatic count_ticks(input int cycles);
		n = 0;
		repeat (cycles) begin
			@(negedge sys_clk);
			n += int'(lowFreqTick === 1'b1);
		end
	endtask
	initial begin
		#2ms;
		failures++;
		finish_test;
	end
	initial begin
		do_reset;
		rw(OP_RD_FLAGS, 16'h0000, 16'h0004);
		for (int i = 0; i < 12; i++) begin
			@(negedge sys_clk) ev = rows[i][27:16];
			@(negedge sys_clk) ev = 12'h000;
			rw(OP_RD_FLAGS, 16'h0000, rows[i][15:0]);
			rw(OP_RD_FLAGS, 16'hFFFF, 16'h0000);
		end
		// an event in the cycle of the clearing read must survive it
		fork
			lfosc_host_model_inst.xfer({OP_RD_FLAGS, 16'h0000}, 24, rdFirst);
			begin
				repeat (64) @(negedge sys_clk);
				ev = 12'h004;
				@(negedge sys_clk) ev = 12'h000;
			end
		join
		lfosc_host_model_inst.xfer({OP_RD_FLAGS, 16'h0000}, 24, rd);
		cmp(rdFirst | rd, 16'h0800);
		rw(OP_WR_OSC, 16'hFFFF, 16'h0000);
		rw(OP_RD_OSC, 16'h0000, 16'h0070);
		cmp(16'({lowFreqBypass, lowFreqOutEnable, oscStop}),
			16'h0007);
		count_ticks(1300);
		cmp(16'(n > 0), 16'h0001);
		rw(8'h81, 16'h0000, 16'h0000);
		lfosc_host_model_inst.xfer({OP_WR_OSC, 16'h0000}, 16, rd);
		rw(OP_RD_OSC, 16'h0000, 16'h0070);
		rw(OP_WR_OSC, 16'h0010, 16'h0000);
		count_ticks(700);
		cmp({oscStop, 15'(n)}, 16'h8000);
		rw(OP_WR_OSC, 16'h0000, 16'h0000);
		count_ticks(700);
		cmp({oscStop, 15'(n > 0)}, 16'h0001);
		rw(OP_WR_OSC, 16'h0070, 16'h0000);
		do_reset;
		rw(OP_RD_OSC, 16'h0000, 16'h0000);
		rw(OP_RD_FLAGS, 16'h0000, 16'h0004);
		finish_test;
	end
endmodule
`default_nettype wire
